// ### hw/acqr_chop_div.sv
// chopper clock divider counting modulator clock ticks
`include "acqr_defs.svh"
`timescale 1ns/1ns
module acqr_chop_div #(
  parameter int CNT_W = `ACQR_CHOP_CNT_W
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       mod_tick_in,
  input  wire logic [1:0] div_sel_in,
  output logic            chopper_clock_out
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             chop_ff;
  logic             nxt_chop;

  // 00 holds high, 01/10/11 take counter bit 7/8/9 (divide 256/512/1024)
  always_comb begin
    nxt_cnt = mod_tick_in ? cnt_ff + 1'b1 : cnt_ff;
    case (div_sel_in)
      2'b00:   nxt_chop = 1'b1;
      2'b01:   nxt_chop = cnt_ff[CNT_W-3];
      2'b10:   nxt_chop = cnt_ff[CNT_W-2];
      2'b11:   nxt_chop = cnt_ff[CNT_W-1];
      default: nxt_chop = 1'b1;
    endcase
  end

  // divider state
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cnt_ff  <= '0;
      chop_ff <= 1'b1;
    end else begin
      cnt_ff  <= nxt_cnt;
      chop_ff <= nxt_chop;
    end
  end

  assign chopper_clock_out = chop_ff;
endmodule : acqr_chop_div

// ### hw/acqr_defs.svh
// register offsets, field positions and reset values of the acquisition bank
`ifndef ACQR_DEFS_SVH
`define ACQR_DEFS_SVH
`define ACQR_ADDR_CUR_HI   7'h00
`define ACQR_ADDR_CUR_LO   7'h01
`define ACQR_ADDR_VOLT_HI  7'h02
`define ACQR_ADDR_VOLT_LO  7'h03
`define ACQR_ADDR_STATUS   7'h04
`define ACQR_ADDR_CTRL_A   7'h05
`define ACQR_RST_BYTE      8'h00
`define ACQR_CTRL_A_RST    8'h45
`define ACQR_ST_CONT1_RDY  7
`define ACQR_ST_CONT2_XING 6
`define ACQR_ST_SBY1_RDY   5
`define ACQR_ST_SBY2_XING  4
`define ACQR_ST_ANALOG_POWER_ON_FLAG       3
`define ACQR_ST_CUR_UPD    2
`define ACQR_ST_VOLT_UPD   1
`define ACQR_CA_DECIM      7
`define ACQR_CA_CHOP_HI    6
`define ACQR_CA_CHOP_LO    5
`define ACQR_CA_COMB_HI    4
`define ACQR_CA_COMB_LO    1
`define ACQR_CA_SAT_MASK   0
`define ACQR_DECIM_LOW     8'h40
`define ACQR_DECIM_HIGH    8'h80
`define ACQR_CHOP_CNT_W    10
`define ACQR_SYNC_RST      4'h1
`endif

// ### hw/acqr_pin_sync.sv
// three-flop pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ns
module acqr_pin_sync #(
  parameter int           W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] pins_out
);
  logic [W-1:0] stg1_ff;
  logic [W-1:0] stg2_ff;
  logic [W-1:0] stg3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // per bit, take the new level only when the last two stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = (stg2_ff[i] == stg3_ff[i]) ? stg3_ff[i] : out_ff[i];
    end
  end

  // shift chain and settled output
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      stg1_ff <= RST;
      stg2_ff <= RST;
      stg3_ff <= RST;
      out_ff  <= RST;
    end else begin
      stg1_ff <= pins_in;
      stg2_ff <= stg1_ff;
      stg3_ff <= stg2_ff;
      out_ff  <= nxt_out;
    end
  end

  assign pins_out = out_ff;
endmodule : acqr_pin_sync

// ### hw/acqr_pkg.sv
// types shared by the acquisition register bank
package acqr_pkg;
  typedef logic [7:0] acqr_byte_t;
  typedef logic [6:0] acqr_addr_t;
  typedef enum logic [1:0] {
    ACQR_IDLE = 2'b00,
    ACQR_CMD  = 2'b01,
    ACQR_WR   = 2'b10,
    ACQR_RD   = 2'b11
  } acqr_spi_state_e;
endpackage : acqr_pkg

// ### hw/acqr_regs.sv
// acquisition result, status and current filter control bank with serial port
//
// Overview of operation
// [R1] current result bits 15:8 read-only at 0x00, reset zero
// [R2] current result bits 7:0 read-only at 0x01, reset zero
// [R3] voltage result bits 15:8 read-only at 0x02, reset zero
// [R4] voltage result bits 7:0 read-only at 0x03, reset zero
// [R5] status bit 2 flags fresh current-channel result
// [R6] status bit 1 flags fresh voltage result; bit 0 reads zero
// [R7] control 0x05 bit 7 picks first decimation 64 or 128, default 64
// [R8] control bits 6:5 chopper: high, or modulator divided 256/512/1024
// [R9] control bits 4:1 second comb ratio is two to the field, default 4
// [R10] status bits 7..3 mode ready, crossing flags and analog power flag
// [R11] serial frame: command bit, 7-bit address, bytes auto-increment address
// [R12] control bit 0 masks current saturation interrupt, default masked
`include "acqr_defs.svh"
`timescale 1ns/1ns
module acqr_regs (
  input  wire logic              ref_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              spi_cs_n_in,
  input  wire logic              spi_sclk_in,
  input  wire logic              spi_sdi_in,
  output logic                   spi_sdo_out,
  output logic                   spi_sdo_oe_out,
  input  wire logic [15:0]       cur_data_in,
  input  wire logic              cur_valid_in,
  input  wire logic [15:0]       volt_data_in,
  input  wire logic              volt_valid_in,
  input  wire logic              cont_one_ready_in,
  input  wire logic              cont_two_cross_in,
  input  wire logic              sby_one_ready_in,
  input  wire logic              sby_two_cross_in,
  input  wire logic              analog_power_on_flag_in,
  input  wire logic              mod_tick_in,
  output logic                   chopper_clock_out,
  output acqr_pkg::acqr_byte_t   decim_factor_out,
  output logic [15:0]            comb_ratio_out,
  output logic                   sat_int_mask_out
);
  import acqr_pkg::*;

  logic [3:0]      pins_s;
  logic            cs_n_s;
  logic            sclk_s;
  logic            sdi_s;
  logic            analog_power_on_flag_s;
  logic            sclk_q_ff;
  logic            cs_q_ff;
  logic            samp_rise_ff;
  logic            nxt_samp_rise;
  acqr_spi_state_e st_ff;
  acqr_spi_state_e nxt_st;
  logic [2:0]      bit_cnt_ff;
  logic [2:0]      nxt_bit_cnt;
  acqr_byte_t      rx_sr_ff;
  acqr_byte_t      nxt_rx_sr;
  acqr_byte_t      tx_sr_ff;
  acqr_byte_t      nxt_tx_sr;
  acqr_addr_t      addr_ff;
  acqr_addr_t      nxt_addr;
  logic            sdo_ff;
  logic            nxt_sdo;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            cs_fall;
  logic            samp;
  logic            xfer;
  logic            wr_en;
  acqr_byte_t      wr_data;
  logic            rd_load;
  acqr_addr_t      ld_addr;
  logic [15:0]     cur_res_ff;
  logic [15:0]     nxt_cur_res;
  logic [15:0]     volt_res_ff;
  logic [15:0]     nxt_volt_res;
  acqr_byte_t      flags_ff;
  acqr_byte_t      nxt_flags;
  acqr_byte_t      status_view;
  acqr_byte_t      ctrl_a_ff;
  acqr_byte_t      nxt_ctrl_a;
  acqr_byte_t      decim_ff;
  logic [15:0]     comb_ff;

  // register contents as seen by the serial port, unmapped reads return zero
  function automatic acqr_byte_t read_mux(input acqr_addr_t a);
    case (a)
      `ACQR_ADDR_CUR_HI:  read_mux = cur_res_ff[15:8];  // R1
      `ACQR_ADDR_CUR_LO:  read_mux = cur_res_ff[7:0];   // R2
      `ACQR_ADDR_VOLT_HI: read_mux = volt_res_ff[15:8]; // R3
      `ACQR_ADDR_VOLT_LO: read_mux = volt_res_ff[7:0];  // R4
      `ACQR_ADDR_STATUS:  read_mux = status_view;
      `ACQR_ADDR_CTRL_A:  read_mux = ctrl_a_ff;
      default:            read_mux = `ACQR_RST_BYTE;
    endcase
  endfunction : read_mux

  // two to the field value
  function automatic logic [15:0] pow2(input logic [3:0] f);
    pow2 = 16'h0001 << f;
  endfunction : pow2

  // serial pins and the analog power flag come from outside this clock
  acqr_pin_sync #(.W(4), .RST(`ACQR_SYNC_RST)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .pins_in    ({analog_power_on_flag_in, spi_sdi_in, spi_sclk_in,
                  spi_cs_n_in}),
    .pins_out   (pins_s)
  );
  assign cs_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[2];
  assign analog_power_on_flag_s = pins_s[3];

  // edges of the settled serial clock and select
  assign sclk_rise = sclk_s & ~sclk_q_ff;
  assign sclk_fall = ~sclk_s & sclk_q_ff;
  assign cs_fall   = ~cs_n_s & cs_q_ff;
  assign samp      = samp_rise_ff ? sclk_rise : sclk_fall;
  assign xfer      = samp_rise_ff ? sclk_fall : sclk_rise;

  // frame engine: command byte, then data bytes at rising addresses
  always_comb begin
    nxt_st        = st_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_rx_sr     = rx_sr_ff;
    nxt_tx_sr     = tx_sr_ff;
    nxt_addr      = addr_ff;
    nxt_sdo       = sdo_ff;
    nxt_samp_rise = samp_rise_ff;
    wr_en         = 1'b0;
    wr_data       = {rx_sr_ff[6:0], sdi_s};
    rd_load       = 1'b0;
    ld_addr       = addr_ff;
    if (cs_fall) begin
      nxt_samp_rise = sclk_s; // clock level at select fall picks edges
    end
    if (cs_n_s) begin
      nxt_st = ACQR_IDLE; // select high ends any frame, partial byte lost
    end else begin
      case (st_ff)
        ACQR_IDLE: begin
          if (cs_fall) begin
            nxt_st      = ACQR_CMD;
            nxt_bit_cnt = 3'h0;
          end
        end
        ACQR_CMD: begin
          if (samp) begin
            nxt_rx_sr   = {rx_sr_ff[6:0], sdi_s};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              nxt_addr = {rx_sr_ff[5:0], sdi_s}; // R11
              if (rx_sr_ff[6]) begin
                nxt_st  = ACQR_RD;
                rd_load = 1'b1;
                ld_addr = {rx_sr_ff[5:0], sdi_s};
              end else begin
                nxt_st = ACQR_WR;
              end
            end
          end
        end
        ACQR_WR: begin
          if (samp) begin
            nxt_rx_sr   = {rx_sr_ff[6:0], sdi_s};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              wr_en    = 1'b1;
              nxt_addr = addr_ff + 7'h01; // R11
            end
          end
        end
        ACQR_RD: begin
          if (xfer) begin
            nxt_sdo   = tx_sr_ff[7];
            nxt_tx_sr = {tx_sr_ff[6:0], 1'b0};
          end
          if (samp) begin
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              nxt_addr = addr_ff + 7'h01; // R11
              rd_load  = 1'b1;
              ld_addr  = addr_ff + 7'h01;
            end
          end
        end
        default: nxt_st = ACQR_IDLE;
      endcase
    end
    if (rd_load) begin
      nxt_tx_sr = read_mux(ld_addr);
    end
  end

  // frame engine state
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st_ff        <= ACQR_IDLE;
      bit_cnt_ff   <= 3'h0;
      rx_sr_ff     <= `ACQR_RST_BYTE;
      tx_sr_ff     <= `ACQR_RST_BYTE;
      addr_ff      <= 7'h00;
      sdo_ff       <= 1'b0;
      samp_rise_ff <= 1'b1;
      sclk_q_ff    <= 1'b0;
      cs_q_ff      <= 1'b1;
    end else begin
      st_ff        <= nxt_st;
      bit_cnt_ff   <= nxt_bit_cnt;
      rx_sr_ff     <= nxt_rx_sr;
      tx_sr_ff     <= nxt_tx_sr;
      addr_ff      <= nxt_addr;
      sdo_ff       <= nxt_sdo;
      samp_rise_ff <= nxt_samp_rise;
      sclk_q_ff    <= sclk_s;
      cs_q_ff      <= cs_n_s;
    end
  end

  assign spi_sdo_out    = sdo_ff;
  assign spi_sdo_oe_out = (st_ff == ACQR_RD) & ~cs_n_s;

  // status view, analog power flag is live and bit 0 reads zero
  assign status_view = {flags_ff[7:4], analog_power_on_flag_s, flags_ff[2:1], 1'b0}; // R6 R10

  // results, sticky flags (cleared when status is read, set wins), control
  always_comb begin
    nxt_cur_res  = cur_valid_in ? cur_data_in : cur_res_ff;    // R1 R2
    nxt_volt_res = volt_valid_in ? volt_data_in : volt_res_ff; // R3 R4
    nxt_flags    = flags_ff;
    if (rd_load && ld_addr == `ACQR_ADDR_STATUS) begin
      nxt_flags = `ACQR_RST_BYTE;
    end
    if (cont_one_ready_in) nxt_flags[`ACQR_ST_CONT1_RDY]  = 1'b1; // R10
    if (cont_two_cross_in) nxt_flags[`ACQR_ST_CONT2_XING] = 1'b1; // R10
    if (sby_one_ready_in)  nxt_flags[`ACQR_ST_SBY1_RDY]   = 1'b1; // R10
    if (sby_two_cross_in)  nxt_flags[`ACQR_ST_SBY2_XING]  = 1'b1; // R10
    if (cur_valid_in)      nxt_flags[`ACQR_ST_CUR_UPD]    = 1'b1; // R5
    if (volt_valid_in)     nxt_flags[`ACQR_ST_VOLT_UPD]   = 1'b1; // R6
    nxt_ctrl_a = ctrl_a_ff;
    if (wr_en && addr_ff == `ACQR_ADDR_CTRL_A) begin
      nxt_ctrl_a = wr_data; // only this register takes writes
    end
  end

  // bank storage and decoded filter settings
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cur_res_ff  <= 16'h0000;
      volt_res_ff <= 16'h0000;
      flags_ff    <= `ACQR_RST_BYTE;
      ctrl_a_ff   <= `ACQR_CTRL_A_RST; // R12
      decim_ff    <= `ACQR_DECIM_LOW;
      comb_ff     <= 16'h0004;
    end else begin
      cur_res_ff  <= nxt_cur_res;
      volt_res_ff <= nxt_volt_res;
      flags_ff    <= nxt_flags;
      ctrl_a_ff   <= nxt_ctrl_a;
      decim_ff    <= ctrl_a_ff[`ACQR_CA_DECIM] ? `ACQR_DECIM_HIGH
                                               : `ACQR_DECIM_LOW; // R7
      comb_ff     <= pow2(ctrl_a_ff[`ACQR_CA_COMB_HI:`ACQR_CA_COMB_LO]); // R9
    end
  end

  assign decim_factor_out = decim_ff;
  assign comb_ratio_out   = comb_ff;
  assign sat_int_mask_out = ctrl_a_ff[`ACQR_CA_SAT_MASK]; // R12

  // chopper clock from the modulator tick
  acqr_chop_div u_chop (
    .ref_clk_in        (ref_clk_in),
    .rstn_in           (rstn_in),
    .mod_tick_in       (mod_tick_in),
    .div_sel_in        (ctrl_a_ff[`ACQR_CA_CHOP_HI:`ACQR_CA_CHOP_LO]), // R8
    .chopper_clock_out (chopper_clock_out)
  );

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_cur_capture;
    cur_valid_in |=> cur_res_ff == $past(cur_data_in);
  endproperty
  a_cur_capture: assert property (p_cur_capture) // R1
    else $error("current result not captured");

  property p_cur_low_read;
    rd_load && ld_addr == `ACQR_ADDR_CUR_LO
      |=> tx_sr_ff == $past(cur_res_ff[7:0]);
  endproperty
  a_cur_low_read: assert property (p_cur_low_read) // R2
    else $error("current low byte read wrong");

  property p_volt_hi_read;
    rd_load && ld_addr == `ACQR_ADDR_VOLT_HI
      |=> tx_sr_ff == $past(volt_res_ff[15:8]);
  endproperty
  a_volt_hi_read: assert property (p_volt_hi_read) // R3
    else $error("voltage high byte read wrong");

  property p_volt_capture;
    volt_valid_in |=> volt_res_ff[7:0] == $past(volt_data_in[7:0]);
  endproperty
  a_volt_capture: assert property (p_volt_capture) // R4
    else $error("voltage low byte not captured");

  property p_cur_flag;
    cur_valid_in |=> status_view[`ACQR_ST_CUR_UPD] ##1 1'b1;
  endproperty
  a_cur_flag: assert property (p_cur_flag) // R5
    else $error("current update flag not set");

  property p_volt_flag;
    volt_valid_in |=> status_view[`ACQR_ST_VOLT_UPD] && !status_view[0];
  endproperty
  a_volt_flag: assert property (p_volt_flag) // R6
    else $error("voltage update flag or reserved bit wrong");

  property p_decim;
    ##1 decim_factor_out == ($past(ctrl_a_ff[`ACQR_CA_DECIM]) ?
                             `ACQR_DECIM_HIGH : `ACQR_DECIM_LOW);
  endproperty
  a_decim: assert property (p_decim) // R7
    else $error("decimation factor wrong");

  property p_chop_high;
    (ctrl_a_ff[`ACQR_CA_CHOP_HI:`ACQR_CA_CHOP_LO] == 2'b00) [*2]
      |-> chopper_clock_out;
  endproperty
  a_chop_high: assert property (p_chop_high) // R8
    else $error("chopper clock not held high");

  property p_comb;
    ##1 comb_ratio_out ==
      pow2($past(ctrl_a_ff[`ACQR_CA_COMB_HI:`ACQR_CA_COMB_LO]));
  endproperty
  a_comb: assert property (p_comb) // R9
    else $error("second comb ratio wrong");

  property p_mode_flag;
    cont_one_ready_in |=> status_view[`ACQR_ST_CONT1_RDY];
  endproperty
  a_mode_flag: assert property (p_mode_flag) // R10
    else $error("continuous ready flag lost");

  property p_addr_inc;
    wr_en |=> addr_ff == $past(addr_ff) + 7'h01;
  endproperty
  a_addr_inc: assert property (p_addr_inc) // R11
    else $error("address did not advance");

  property p_ctrl_reset;
    disable iff (1'b0) !rstn_in |=> ctrl_a_ff == `ACQR_CTRL_A_RST;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) // R12
    else $error("control register reset value wrong");
endmodule : acqr_regs

// ### sim/acqr_spi_master.sv
// serial port master model driving select, clock and data of the bank
`timescale 1ns/1ns
module acqr_spi_master (
  input  wire logic ref_clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  int   half = 10;   // ref clocks per serial clock half period
  logic idle = 1'b1; // serial clock level while no bit is moving

  // select and clock idle high, data parked low before the first frame
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // wait n rising edges of the reference clock
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : wait_clk

  // park the clock at pol, then select: pol picks the sampling edge
  task automatic start(input logic pol);
    @(posedge ref_clk_in);
    sclk_out <= pol;
    idle = pol;
    wait_clk(half);
    cs_n_out <= 1'b0;
    wait_clk(half);
  endtask : start

  // move nbits msb first, data changes on the edge away from idle
  task automatic shift(input logic [7:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk_out <= ~idle;
      sdi_out  <= tx[i];
      wait_clk(half);
      sclk_out <= idle;
      // a read bit only counts while the bank drives the line
      rx[i] = (sdo_oe_in === 1'b1) ? sdo_in : 1'bx;
      wait_clk(half);
    end
  endtask : shift

  // deselect; released data line shows the inverse of its last level
  task automatic stop();
    cs_n_out <= 1'b1;
    sdi_out  <= ~sdi_out;
    wait_clk(2 * half);
  endtask : stop
endmodule : acqr_spi_master

// ### sim/test_acqr_regs.sv
// self-checking bench for the acquisition register bank
`timescale 1ns/1ns
module test_acqr_regs;
  import acqr_pkg::*;
  logic        ref_clk_in, rstn_in, cs_n, sclk, sdi, sdo, sdo_oe;
  logic [15:0] cur_data, volt_data, comb;
  logic        cur_valid, volt_valid, c1, c2, s1, s2, analog_power_on_flag, tick;
  logic        chop, mask;
  acqr_byte_t  decim;
  int          n_fail     = 0;
  int          n_compared = 0;

  acqr_regs u_acqr_regs (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .spi_cs_n_in(cs_n),
    .spi_sclk_in(sclk), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
    .spi_sdo_oe_out(sdo_oe), .cur_data_in(cur_data),
    .cur_valid_in(cur_valid), .volt_data_in(volt_data),
    .volt_valid_in(volt_valid), .cont_one_ready_in(c1),
    .cont_two_cross_in(c2), .sby_one_ready_in(s1),
    .sby_two_cross_in(s2), .analog_power_on_flag_in(analog_power_on_flag),
    .mod_tick_in(tick), .chopper_clock_out(chop),
    .decim_factor_out(decim), .comb_ratio_out(comb),
    .sat_int_mask_out(mask));

  acqr_spi_master u_acqr_spi_master (
    .ref_clk_in(ref_clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
    .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));

  // 250 MHz reference clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // compare, count and report a mismatch at once
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask : chk

  // read a burst starting at a and compare each byte
  task automatic rd(input logic [6:0] a, input logic [7:0] exp [$],
                    input logic pol);
    logic [7:0] rx;
    u_acqr_spi_master.start(pol);
    u_acqr_spi_master.shift({1'b1, a}, 8, rx);
    foreach (exp[i]) begin
      u_acqr_spi_master.shift(8'h00, 8, rx);
      chk({8'h00, rx}, {8'h00, exp[i]}, "read byte");
    end
    u_acqr_spi_master.stop();
  endtask : rd

  // write a burst starting at a
  task automatic wr(input logic [6:0] a, input logic [7:0] d [$],
                    input logic pol);
    logic [7:0] rx;
    u_acqr_spi_master.start(pol);
    u_acqr_spi_master.shift({1'b0, a}, 8, rx);
    foreach (d[i]) u_acqr_spi_master.shift(d[i], 8, rx);
    u_acqr_spi_master.stop();
  endtask : wr

  // run 1024 modulator ticks and count chopper output changes
  task automatic chop_run(input int exp_n);
    int   n = 0;
    logic prev;
    prev = chop;
    for (int i = 0; i < 1040; i++) begin
      @(posedge ref_clk_in);
      tick <= (i < 1024);
      if (chop !== prev) n++;
      prev = chop;
    end
    chk(n[15:0], exp_n[15:0], "chopper toggles");
    if (exp_n == 0) chk({15'h0, chop}, 16'h0001, "chopper held");
  endtask : chop_run

  // reset values of all six registers and of the decimation, comb and mask outputs
  task automatic t_reset();
    rd(7'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h45}, 1'b1);
    chk({8'h00, decim}, 16'h0040, "decimation");
    chk(comb, 16'h0004, "comb ratio");
    chk({15'h0, mask}, 16'h0001, "saturation mask");
    $display("reset values done");
  endtask : t_reset

  // result capture, update flags and their clearing by a status read
  task automatic t_results();
    @(posedge ref_clk_in);
    cur_data   <= 16'hA55A;
    cur_valid  <= 1'b1;
    volt_data  <= 16'h3CC3;
    volt_valid <= 1'b1;
    @(posedge ref_clk_in);
    cur_valid  <= 1'b0;
    volt_valid <= 1'b0;
    cur_data   <= 16'h0000;
    volt_data  <= 16'hFFFF;
    rd(7'h04, '{8'h06}, 1'b1);
    rd(7'h00, '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h00}, 1'b0);
    $display("results done");
  endtask : t_results

  // mode flags are sticky, the analog power flag is live
  task automatic t_flags();
    @(posedge ref_clk_in);
    {c1, c2, s1, s2} <= 4'hF;
    analog_power_on_flag             <= 1'b1;
    @(posedge ref_clk_in);
    {c1, c2, s1, s2} <= 4'h0;
    repeat (10) @(posedge ref_clk_in);
    rd(7'h04, '{8'hF8, 8'h45}, 1'b1);
    rd(7'h04, '{8'h08}, 1'b0);
    analog_power_on_flag <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    rd(7'h04, '{8'h00}, 1'b1);
    $display("status flags done");
  endtask : t_flags

  // every chopper setting, both decimation factors, comb and mask fields
  task automatic t_ctrl();
    logic [7:0] cv [4] = '{8'h00, 8'hA3, 8'h5E, 8'hE8};
    logic [1:0] f;
    for (int k = 0; k < 4; k++) begin
      f = cv[k][6:5];
      wr(7'h05, '{cv[k]}, k[0]);
      chk({8'h00, decim}, cv[k][7] ? 16'h0080 : 16'h0040, "decim");
      chk(comb, 16'h0001 << cv[k][4:1], "comb ratio");
      chk({15'h0, mask}, {15'h0, cv[k][0]}, "mask");
      chop_run((f == 2'b00) ? 0 : (16 >> f));
      rd(7'h05, '{cv[k]}, ~k[0]);
    end
    $display("control register done");
  endtask : t_ctrl

  // read-only and unmapped places, partial bytes and address wrap
  task automatic t_refuse();
    logic [7:0] rx;
    wr(7'h04, '{8'h11, 8'h3C}, 1'b1);
    wr(7'h00, '{8'hFF, 8'hFF, 8'hFF, 8'hFF}, 1'b0);
    rd(7'h00, '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h00, 8'h3C}, 1'b1);
    u_acqr_spi_master.start(1'b1);
    u_acqr_spi_master.shift(8'h05, 8, rx);
    u_acqr_spi_master.shift(8'hFF, 4, rx);
    u_acqr_spi_master.stop();
    rd(7'h05, '{8'h3C}, 1'b0);
    rd(7'h10, '{8'h00}, 1'b1);
    rd(7'h7F, '{8'h00, 8'hA5}, 1'b0);
    $display("refused accesses done");
  endtask : t_refuse

  // print the counts and the verdict, then stop
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // cut a hang short well beyond the expected run length
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial begin
    rstn_in = 1'b0;
    {cur_valid, volt_valid, c1, c2, s1, s2, analog_power_on_flag, tick} = 8'h00;
    cur_data  = 16'h0000;
    volt_data = 16'h0000;
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    t_reset();
    t_results();
    t_flags();
    t_ctrl();
    t_refuse();
    end_of_test();
  end
endmodule : test_acqr_regs
